// file: common/tmr8_pkg.sv
// Shared constants and types for the dual 8-bit timer/event counter
package tmr8_pkg;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [15:0] ADDR_CNT0  = 16'hFF2C;  // Counter value, ch0
  localparam logic [15:0] ADDR_CMP0  = 16'hFF2D;  // Compare value, ch0
  localparam logic [15:0] ADDR_CSEL0 = 16'hFF2E;  // Clock select, ch0
  localparam logic [15:0] ADDR_MODE0 = 16'hFF2F;  // Mode control, ch0
  localparam logic [15:0] ADDR_CNT1  = 16'hFF3C;  // Counter value, ch1
  localparam logic [15:0] ADDR_CMP1  = 16'hFF3D;  // Compare value, ch1
  localparam logic [15:0] ADDR_CSEL1 = 16'hFF3E;  // Clock select, ch1
  localparam logic [15:0] ADDR_MODE1 = 16'hFF3F;  // Mode control, ch1

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;  // Every register clears to this
  localparam logic [2:0] RST_CSEL = 3'h0;   // Clock select field reset

  // ****************************************************************
  // Mode control field positions
  // ****************************************************************
  localparam int MODE_EN_BIT  = 7;  // Count enable
  localparam int MODE_PWM_BIT = 6;  // 0 clear-on-match, 1 PWM
  localparam int MODE_SET_BIT = 3;  // Output flip-flop set
  localparam int MODE_RST_BIT = 2;  // Output flip-flop reset
  localparam int MODE_INV_BIT = 1;  // Inversion / active-low
  localparam int MODE_OE_BIT  = 0;  // Output enable
  localparam logic [7:0] MODE0_MASK = 8'hC3;  // Stored bits, ch0
  localparam logic [7:0] MODE1_MASK = 8'hC0;  // Stored bits, ch1

  // ****************************************************************
  // Clock select codes and prescaler taps
  // ****************************************************************
  localparam int CSEL_W     = 3;        // Clock select field width
  localparam int PRESC_W    = 13;       // Prescaler width, up to main clock /8192
  localparam logic [2:0] CS_EV_FALL = 3'h0;  // Ch0 event input falling
  localparam logic [2:0] CS_EV_RISE = 3'h1;  // Ch0 event input rising
  localparam logic [2:0] CS_DIV2    = 3'h2;
  localparam logic [2:0] CS_DIV_A   = 3'h3;
  localparam logic [2:0] CS_DIV_B   = 3'h4;
  localparam logic [2:0] CS_DIV_C   = 3'h5;
  localparam logic [2:0] CS_DIV_D   = 3'h6;
  localparam logic [2:0] CS_DIV_E   = 3'h7;
  // Divide exponents per code, ch0
  localparam int CH0_EXP [8] = '{0, 0, 1, 2, 4, 6, 8, 13};
  // Divide exponents per code, ch1 (code 7 uses the low-speed oscillator)
  localparam int CH1_EXP [8] = '{0, 0, 1, 5, 7, 10, 13, 7};
  localparam int LS_EXP      = 7;       // Low-speed oscillator divide /128

  // ****************************************************************
  // Operating mode
  // ****************************************************************
  typedef enum logic {MODE_CLEAR, MODE_PWM} tmr8_mode_t;

endpackage

// file: src/tmr8_chan.sv
// One 8-bit counter with compare, clear and overflow logic
`timescale 1ns/100ps
module tmr8_chan
  import tmr8_pkg::*;
#(
  parameter int WIDTH = 8   // Counter width
)(
  // Clock, reset, enable
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  // Control
  input  wire logic             tick_i,     // Selected count clock edge
  input  wire logic             run_i,      // Count enable bit
  input  wire tmr8_mode_t       mode_i,     // Clear-on-match or PWM
  input  wire logic [WIDTH-1:0] cmp_i,      // Compare value
  // Status
  output logic      [WIDTH-1:0] cnt_o,      // Counter value
  output logic                  match_o,    // Equality pulse, any mode
  output logic                  ovf_o,      // Overflow pulse
  output logic                  irq_o       // Match interrupt pulse
);

  // ****************************************************************
  // Counter state
  // ****************************************************************
  logic [WIDTH-1:0] cnt_q, cnt_d;     // Counter
  logic             match_q, match_d; // Equality seen on a count
  logic             ovf_q, ovf_d;     // Wrap seen on a count
  logic             irq_q, irq_d;     // Interrupt pulse
  logic             eq;               // Counter equals compare

  // Next-state of counter and pulses
  always_comb
  begin
    eq      = (cnt_q == cmp_i);
    cnt_d   = cnt_q;
    match_d = 1'b0;
    ovf_d   = 1'b0;
    irq_d   = 1'b0;
    if (!run_i)
    begin
      // Stopped: counter held at zero
      cnt_d = '0;
    end
    else if (tick_i)
    begin
      match_d = eq;
      ovf_d   = &cnt_q;
      // One interrupt per equality, outside PWM only
      irq_d   = eq && (mode_i == MODE_CLEAR);
      if (eq && (mode_i == MODE_CLEAR))
        cnt_d = '0;
      else
        cnt_d = cnt_q + 1'b1;
    end
  end

  // Register counter and pulses
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q   <= '0;
      match_q <= 1'b0;
      ovf_q   <= 1'b0;
      irq_q   <= 1'b0;
    end
    else if (ce_i)
    begin
      cnt_q   <= cnt_d;
      match_q <= match_d;
      ovf_q   <= ovf_d;
      irq_q   <= irq_d;
    end
  end

  assign cnt_o   = cnt_q;
  assign match_o = match_q;
  assign ovf_o   = ovf_q;
  assign irq_o   = irq_q;

endmodule

// file: src/tmr8_top.sv
// Dual 8-bit timer/event counter with CPU register port
//
// How it works
// - Read-only 8-bit counter steps on count clock
// - Counter clears on reset, stop, clear-mode match
// - Outside PWM, equality raises the channel interrupt
// - Ch0 PWM output active on overflow, inactive on match
// - Compare register holds any byte, resets zero
// - Ch0 clock select: event edges or divided clock
// - Ch1 clock select: divided or low-speed clock
// - Clock select resets zero, low three bits writable
// - Mode control holds four settings on ch0, two on ch1, resets zero
// - Enable bit starts count; clearing stops, clears
// - Mode bit picks clear-on-match or PWM
`timescale 1ns/100ps
module tmr8_top
  import tmr8_pkg::*;
#(
  parameter int DATA_W = 8   // Register width
)(
  // Clock, reset, clock enable
  input  wire logic              MCLK_I,
  input  wire logic              RSTN_I,
  input  wire logic              CE_I,
  // CPU memory access port
  input  wire logic [15:0]       ADDR_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  input  wire logic [DATA_W-1:0] WDATA_I,
  output logic      [DATA_W-1:0] RDATA_O,
  // Timer pins and clock sources
  input  wire logic              EVENT_IN_I,   // Ch0 external count input
  input  wire logic              LS_OSC_TICK_I,// One pulse per low-speed cycle
  output logic                   TIMER_OUT_O,  // Ch0 timer output pin
  // Interrupts
  output logic                   MATCH_IRQ0_O,
  output logic                   MATCH_IRQ1_O
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Tick when the low 'e' prescaler bits are all ones
  function automatic logic div_tick(input logic [PRESC_W-1:0] p, input int e);
    logic [PRESC_W-1:0] m;
    m = PRESC_W'((1 << e) - 1);
    return (p & m) == m;
  endfunction

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [DATA_W-1:0] cmp0_q, cmp0_d;     // Compare value, ch0
  logic [DATA_W-1:0] cmp1_q, cmp1_d;     // Compare value, ch1
  logic [CSEL_W-1:0] csel0_q, csel0_d;   // Clock select, ch0
  logic [CSEL_W-1:0] csel1_q, csel1_d;   // Clock select, ch1
  logic [DATA_W-1:0] mode0_q, mode0_d;   // Mode control, ch0
  logic [DATA_W-1:0] mode1_q, mode1_d;   // Mode control, ch1
  logic [DATA_W-1:0] rdata_q, rdata_d;   // Read data
  logic [PRESC_W-1:0] presc_q, presc_d;  // Main clock prescaler
  logic [LS_EXP-1:0] ls_q, ls_d;         // Low-speed divider
  logic              ev_q, ev_d;         // Previous event input level
  logic              tof_q, tof_d;       // Timer output flip-flop
  logic              pin_q, pin_d;       // Timer output pin
  logic [DATA_W-1:0] cnt0, cnt1;         // Counter values
  logic              tick0, tick1;       // Selected count edges
  logic              m0, o0, m1;         // Match and overflow pulses
  logic              irq0, irq1;         // Interrupt pulses
  tmr8_mode_t        md0, md1;           // Decoded modes

  assign md0 = tmr8_mode_t'(mode0_q[MODE_PWM_BIT]);
  assign md1 = tmr8_mode_t'(mode1_q[MODE_PWM_BIT]);

  // ****************************************************************
  // Count clock selection
  // ****************************************************************
  // Prescaler, low-speed divider and edge detection
  always_comb
  begin
    presc_d = presc_q + 1'b1;
    ls_d    = LS_OSC_TICK_I ? ls_q + 1'b1 : ls_q;
    ev_d    = EVENT_IN_I;
    // Ch0 source
    case (csel0_q)
      CS_EV_FALL: tick0 = ev_q && !EVENT_IN_I;
      CS_EV_RISE: tick0 = !ev_q && EVENT_IN_I;
      default:    tick0 = div_tick(presc_q, CH0_EXP[csel0_q]);
    endcase
    // Ch1 source; codes 0 and 1 never count
    case (csel1_q)
      CS_EV_FALL, CS_EV_RISE: tick1 = 1'b0;
      CS_DIV_E:   tick1 = LS_OSC_TICK_I && (&ls_q);
      default:    tick1 = div_tick(presc_q, CH1_EXP[csel1_q]);
    endcase
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RSTN_I)
    begin
      presc_q <= '0;
      ls_q    <= '0;
      ev_q    <= 1'b0;
    end
    else if (CE_I)
    begin
      presc_q <= presc_d;
      ls_q    <= ls_d;
      ev_q    <= ev_d;
    end
  end

  // ****************************************************************
  // Channels
  // ****************************************************************
  tmr8_chan #(.WIDTH(DATA_W)) u_ch0 (
    .clk_i   (MCLK_I),
    .rst_n_i (RSTN_I),
    .ce_i    (CE_I),
    .tick_i  (tick0),
    .run_i   (mode0_q[MODE_EN_BIT]),
    .mode_i  (md0),
    .cmp_i   (cmp0_q),
    .cnt_o   (cnt0),
    .match_o (m0),
    .ovf_o   (o0),
    .irq_o   (irq0)
  );

  tmr8_chan #(.WIDTH(DATA_W)) u_ch1 (
    .clk_i   (MCLK_I),
    .rst_n_i (RSTN_I),
    .ce_i    (CE_I),
    .tick_i  (tick1),
    .run_i   (mode1_q[MODE_EN_BIT]),
    .mode_i  (md1),
    .cmp_i   (cmp1_q),
    .cnt_o   (cnt1),
    .match_o (m1),
    .ovf_o   (),
    .irq_o   (irq1)
  );

  assign MATCH_IRQ0_O = irq0;
  assign MATCH_IRQ1_O = irq1;

  // ****************************************************************
  // Register access and timer output
  // ****************************************************************
  // Decode writes, build read data, drive output flip-flop
  always_comb
  begin
    cmp0_d  = cmp0_q;
    cmp1_d  = cmp1_q;
    csel0_d = csel0_q;
    csel1_d = csel1_q;
    mode0_d = mode0_q;
    mode1_d = mode1_q;
    tof_d   = tof_q;
    rdata_d = RST_BYTE;  // Unmapped reads return zero
    // Writes; counter registers ignore them
    if (WR_I)
    begin
      case (ADDR_I)
        ADDR_CMP0:  cmp0_d  = WDATA_I;
        ADDR_CMP1:  cmp1_d  = WDATA_I;
        ADDR_CSEL0: csel0_d = WDATA_I[CSEL_W-1:0];
        ADDR_CSEL1: csel1_d = WDATA_I[CSEL_W-1:0];
        ADDR_MODE0: mode0_d = WDATA_I & MODE0_MASK;
        ADDR_MODE1: mode1_d = WDATA_I & MODE1_MASK;
        default:    ;
      endcase
    end
    // Reads; set/reset bits always read zero
    if (RD_I)
    begin
      case (ADDR_I)
        ADDR_CNT0:  rdata_d = cnt0;
        ADDR_CNT1:  rdata_d = cnt1;
        ADDR_CMP0:  rdata_d = cmp0_q;
        ADDR_CMP1:  rdata_d = cmp1_q;
        ADDR_CSEL0: rdata_d = {5'h00, csel0_q};
        ADDR_CSEL1: rdata_d = {5'h00, csel1_q};
        ADDR_MODE0: rdata_d = mode0_q;
        ADDR_MODE1: rdata_d = mode1_q;
        default:    rdata_d = RST_BYTE;
      endcase
    end
    // Output flip-flop behaviour by mode
    if (md0 == MODE_PWM)
    begin
      if (!mode0_q[MODE_EN_BIT])
        tof_d = 1'b0;
      else if (o0)
        tof_d = 1'b1;
      else if (m0)
        tof_d = 1'b0;
    end
    else
    begin
      // Direct set/reset from a mode write
      if (WR_I && ADDR_I == ADDR_MODE0 && WDATA_I[MODE_SET_BIT]
          && !WDATA_I[MODE_RST_BIT])
        tof_d = 1'b1;
      else if (WR_I && ADDR_I == ADDR_MODE0 && WDATA_I[MODE_RST_BIT]
               && !WDATA_I[MODE_SET_BIT])
        tof_d = 1'b0;
      else if (m0 && mode0_q[MODE_INV_BIT])
        tof_d = !tof_q;
    end
    // Pin: low when disabled, polarity from inversion bit in PWM
    if (!mode0_q[MODE_OE_BIT])
      pin_d = 1'b0;
    else if (md0 == MODE_PWM)
      pin_d = tof_q ^ mode0_q[MODE_INV_BIT];
    else
      pin_d = tof_q;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RSTN_I)
    begin
      cmp0_q  <= RST_BYTE;
      cmp1_q  <= RST_BYTE;
      csel0_q <= RST_CSEL;
      csel1_q <= RST_CSEL;
      mode0_q <= RST_BYTE;
      mode1_q <= RST_BYTE;
      rdata_q <= RST_BYTE;
      tof_q   <= 1'b0;
      pin_q   <= 1'b0;
    end
    else if (CE_I)
    begin
      cmp0_q  <= cmp0_d;
      cmp1_q  <= cmp1_d;
      csel0_q <= csel0_d;
      csel1_q <= csel1_d;
      mode0_q <= mode0_d;
      mode1_q <= mode1_d;
      rdata_q <= rdata_d;
      tof_q   <= tof_d;
      pin_q   <= pin_d;
    end
  end

  assign RDATA_O     = rdata_q;
  assign TIMER_OUT_O = pin_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I || !CE_I);

  a_cnt_step: assert property (
    mode0_q[MODE_EN_BIT] && tick0 && !(cnt0 == cmp0_q && md0 == MODE_CLEAR)
    ##1 CE_I |-> cnt0 == $past(cnt0) + 8'h01)
    else $error("ch0 counter did not step on count edge");
  a_cnt_stop: assert property (
    !mode1_q[MODE_EN_BIT] ##1 CE_I |-> cnt1 == 8'h00)
    else $error("ch1 counter not cleared while stopped");
  a_clear_match: assert property (
    mode0_q[MODE_EN_BIT] && tick0 && md0 == MODE_CLEAR && cnt0 == cmp0_q
    ##1 CE_I |-> cnt0 == 8'h00 && MATCH_IRQ0_O)
    else $error("clear-on-match did not clear and interrupt");
  a_irq_pwm: assert property (
    md1 == MODE_PWM ##1 CE_I |-> !MATCH_IRQ1_O)
    else $error("interrupt raised in PWM mode");
  a_irq_pulse: assert property (
    MATCH_IRQ0_O ##1 CE_I |-> !MATCH_IRQ0_O || cmp0_q == 8'h00)
    else $error("interrupt held longer than one count");
  a_pwm_active: assert property (
    md0 == MODE_PWM && mode0_q[MODE_EN_BIT] && o0 ##1 CE_I |-> tof_q)
    else $error("PWM output not active after overflow");
  a_pwm_idle: assert property (
    md0 == MODE_PWM && mode0_q[MODE_EN_BIT] && m0 && !o0 ##1 CE_I |-> !tof_q)
    else $error("PWM output not inactive after match");
  a_cmp_write: assert property (
    WR_I && ADDR_I == ADDR_CMP1 ##1 CE_I |-> cmp1_q == $past(WDATA_I))
    else $error("compare write lost");
  a_csel_read: assert property (
    RD_I && ADDR_I == ADDR_CSEL0 && !WR_I ##1 CE_I
    |-> RDATA_O == {5'h00, $past(csel0_q)})
    else $error("clock select readback wrong");
  a_div2_tick: assert property (
    csel0_q == CS_DIV2 && tick0 ##1 CE_I && csel0_q == CS_DIV2 |-> !tick0)
    else $error("divide-by-2 ticked twice in a row");
  a_ch1_prohib: assert property (
    (csel1_q == CS_EV_FALL || csel1_q == CS_EV_RISE) && mode1_q[MODE_EN_BIT]
    ##1 CE_I |-> cnt1 == $past(cnt1) && !MATCH_IRQ1_O)
    else $error("prohibited ch1 code produced a count");
  a_oe_low: assert property (
    !mode0_q[MODE_OE_BIT] ##1 CE_I |-> !TIMER_OUT_O)
    else $error("output not low while disabled");

  c_irq0: cover property (MATCH_IRQ0_O);
  c_pwm_cycle: cover property (md0 == MODE_PWM && o0 ##[1:600] m0);
  c_event_cnt: cover property (csel0_q == CS_EV_RISE && tick0);
  c_ls_tick: cover property (csel1_q == CS_DIV_E && tick1);

endmodule

// file: tb/tb_top.sv
// Self-checking bench for the dual 8-bit timer/event counter
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top
  import tmr8_pkg::*;
;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int LS_PER = 3;          // Low-speed tick spacing, cycles
  logic        mclk, rstn, ce, ev_in, ls_tick, ev_auto, ev_man, pinv;
  logic [15:0] addr;
  logic        wr, rd, rd_take, irq0_p, irq1_p, tout, irq0, irq1;
  logic [7:0]  wdata, rdata, e_rd, v;
  logic [7:0]  exp_q [$];             // Expected read data, oldest first
  int          error_cnt, checked, cyc, n0, n1, last0, last1, gap0, gap1;
  int          i, k, c, base;
  int          div0 [8] = '{6, 6, 2, 4, 16, 64, 256, 8192};
  int          div1 [8] = '{0, 0, 2, 32, 128, 1024, 8192, 128 * LS_PER};
  logic [15:0] amap [9] = '{ADDR_CNT0, ADDR_CMP0, ADDR_CSEL0, ADDR_MODE0,
                            ADDR_CNT1, ADDR_CMP1, ADDR_CSEL1, ADDR_MODE1, 16'hFF30};

  // ****************************************************************
  // Design and CPU model
  // ****************************************************************
  tmr8_top u_tmr8_top (.MCLK_I(mclk), .RSTN_I(rstn), .CE_I(ce), .ADDR_I(addr),
    .WR_I(wr), .RD_I(rd), .WDATA_I(wdata), .RDATA_O(rdata), .EVENT_IN_I(ev_in),
    .LS_OSC_TICK_I(ls_tick), .TIMER_OUT_O(tout), .MATCH_IRQ0_O(irq0),
    .MATCH_IRQ1_O(irq1));
  tmr8_cpu_bfm u_tmr8_cpu_bfm (.clk_i(mclk), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata));

  // 40 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Event input, low-speed ticks and the hang limit
  always @(posedge mclk)
  begin
    cyc     <= cyc + 1;
    ev_in   <= ev_auto ? (cyc % 6 < 3) : ev_man;
    ls_tick <= (cyc % LS_PER == 0);
    if (cyc >= 100000)
    begin
      error_cnt++;
      close_out();
    end
  end

  // ****************************************************************
  // Monitor: read data against notes, interrupt spacing
  // ****************************************************************
  always @(posedge mclk) rd_take <= rd & rstn;
  always @(negedge mclk)
  begin
    if (rd_take)
    begin
      e_rd = exp_q.pop_front();
      `CHK(rdata, e_rd)
    end
    if (irq0)
    begin
      `CHK(irq0_p, 1'b0)
      gap0 = cyc - last0;
      last0 = cyc;
      n0++;
    end
    if (irq1)
    begin
      `CHK(irq1_p, 1'b0)
      gap1 = cyc - last1;
      last1 = cyc;
      n1++;
    end
    irq0_p = irq0;
    irq1_p = irq1;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic w(input logic [15:0] a, input logic [7:0] d);
    u_tmr8_cpu_bfm.wr(a, d);
  endtask

  // Note the expected byte, then read
  task automatic rdx(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_tmr8_cpu_bfm.rd(a);
  endtask

  // One event pulse, edges two cycles apart (10 MHz)
  task automatic pulse();
    @(posedge mclk);
    ev_man <= 1'b1;
    repeat (2) @(posedge mclk);
    ev_man <= 1'b0;
    @(posedge mclk);
  endtask

  // Interval run on one clock source code
  task automatic run_code(input bit ch, input int cd);
    int n, d, b, j;
    d = ch ? div1[cd] : div0[cd];
    n = (d > 1024) ? 0 : $urandom % 4;
    w(ch ? ADDR_MODE1 : ADDR_MODE0, 8'h00);
    w(ch ? ADDR_CSEL1 : ADDR_CSEL0, 8'(cd));
    w(ch ? ADDR_CMP1 : ADDR_CMP0, 8'(n));
    w(ch ? ADDR_MODE1 : ADDR_MODE0, 8'h80);
    b = ch ? n1 : n0;
    for (j = 0; j < 3 * (n + 1) * d + 50 && (ch ? n1 : n0) < b + 2; j++) @(negedge mclk);
    `CHK((ch ? n1 : n0) - b, 2)
    `CHK(ch ? gap1 : gap0, (n + 1) * d)
    w(ch ? ADDR_MODE1 : ADDR_MODE0, 8'h00);
  endtask

  // Count cycles until the active level reaches lv
  task automatic lvl_wait(input logic lv, output int cnt);
    cnt = 0;
    while ((tout ^ pinv) !== lv && cnt < 3000)
    begin
      @(negedge mclk);
      cnt++;
    end
  endtask

  // PWM duty and period at main clock /4, either active level
  task automatic pwm(input logic inv);
    int cv, hi, lo, b;
    cv = 8 + $urandom % 200;
    b = n0;
    pinv = inv;
    w(ADDR_MODE0, 8'h00);
    w(ADDR_CSEL0, 8'h03);
    w(ADDR_CMP0, 8'(cv));
    w(ADDR_MODE0, inv ? 8'hC3 : 8'hC1);
    lvl_wait(1'b0, hi);
    lvl_wait(1'b1, hi);
    lvl_wait(1'b0, hi);
    lvl_wait(1'b1, lo);
    `CHK(hi, (cv + 1) * 4)
    `CHK(hi + lo, 1024)
    `CHK(n0, b)
  endtask

  // Verdict and end of run
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    rstn    = 1'b0;
    ce      = 1'b1;
    ev_auto = 1'b1;
    ev_man  = 1'b0;
    pinv    = 1'b0;
    void'($urandom(15));
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    // Reset values, unmapped read
    foreach (amap[j]) rdx(amap[j], 8'h00);
    // Compare registers, full range
    for (i = 0; i < 4; i++)
    begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      w(ADDR_CMP0, v);
      w(ADDR_CMP1, ~v);
      rdx(ADDR_CMP0, v);
      rdx(ADDR_CMP1, ~v);
    end
    // Every clock select code, channel stopped
    for (i = 0; i < 8; i++)
    begin
      w(ADDR_CSEL0, 8'(i));
      w(ADDR_CSEL1, 8'(i));
      rdx(ADDR_CSEL0, 8'(i));
      rdx(ADDR_CSEL1, 8'(i));
    end
    // Mode registers keep only their defined bits
    w(ADDR_MODE0, 8'hF3);
    w(ADDR_MODE1, 8'hC0);
    rdx(ADDR_MODE0, 8'hC3);
    rdx(ADDR_MODE1, 8'hC0);
    w(ADDR_MODE0, 8'h00);
    w(ADDR_MODE1, 8'h00);
    // Counter is read-only, unmapped write lost
    w(ADDR_CNT0, 8'h5A);
    w(16'hFF30, 8'h55);
    rdx(ADDR_CNT0, 8'h00);
    rdx(16'hFF30, 8'h00);
    // Counting event edges by hand
    ev_auto <= 1'b0;
    w(ADDR_CSEL0, 8'h01);
    w(ADDR_CMP0, 8'hFF);
    w(ADDR_MODE0, 8'h80);
    k = 5 + $urandom % 20;
    repeat (k) pulse();
    // Clock enable low: an event edge must not count
    ce <= 1'b0;
    pulse();
    ce <= 1'b1;
    rdx(ADDR_CNT0, 8'(k));
    w(ADDR_MODE0, 8'h00);
    rdx(ADDR_CNT0, 8'h00);
    // Clear and restart on match
    w(ADDR_CMP0, 8'h03);
    base = n0;
    w(ADDR_MODE0, 8'h80);
    repeat (4) pulse();
    rdx(ADDR_CNT0, 8'h00);
    pulse();
    rdx(ADDR_CNT0, 8'h01);
    `CHK(n0 - base, 1)
    w(ADDR_MODE0, 8'h00);
    ev_auto <= 1'b1;
    // Interval per source; main clock /2 exceeds the count clock limit
    for (c = 0; c < 8; c++) if (c != 2) run_code(1'b0, c);
    for (c = 3; c < 8; c++) run_code(1'b1, c);
    // Prohibited channel 1 codes never count
    for (c = 0; c < 2; c++)
    begin
      base = n1;
      w(ADDR_CSEL1, 8'(c));
      w(ADDR_CMP1, 8'h00);
      w(ADDR_MODE1, 8'h80);
      repeat (200) @(negedge mclk);
      rdx(ADDR_CNT1, 8'h00);
      `CHK(n1, base)
      w(ADDR_MODE1, 8'h00);
    end
    pwm(1'b0);
    pwm(1'b1);
    // Timer flip-flop: direct set, direct reset, then toggle on match
    w(ADDR_MODE0, 8'h00);
    w(ADDR_MODE0, 8'h09);
    repeat (2) @(negedge mclk);
    `CHK(tout, 1'b1)
    w(ADDR_MODE0, 8'h05);
    repeat (2) @(negedge mclk);
    `CHK(tout, 1'b0)
    w(ADDR_CMP0, 8'h1F);
    w(ADDR_MODE0, 8'h83);
    pinv = 1'b0;
    lvl_wait(1'b1, i);
    lvl_wait(1'b0, i);
    `CHK(i, 128)
    // Output disabled reads low
    w(ADDR_MODE0, 8'h00);
    repeat (3) @(negedge mclk);
    `CHK(tout, 1'b0)
    close_out();
  end
endmodule

// file: tb/tmr8_cpu_bfm.sv
// CPU-side memory access model driving the timer register port
`timescale 1ns/100ps
module tmr8_cpu_bfm
  import tmr8_pkg::*;
(
  // Clock
  input  wire logic        clk_i,
  // Memory access port
  output logic      [15:0] addr_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic      [7:0]  wdata_o
);
  // Idle bus at time zero
  initial
  begin
    addr_o  = 16'h0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 8'h00;
  end

  // One byte write, held for one taken edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    // Released lines show the inverse, never the stale value
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask

  // One byte read; data is judged by the bench monitor
  task automatic rd(input logic [15:0] a);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
  endtask
endmodule
